// >>> logic/clk_cfg.sv
// clock configuration registers: prescale, slowdown, feedback divisor, module gating
// assumes a same-clock register master and an interrupt request level from the core
// ------------------------------------------------------------
// Notes on behaviour
// - pll prescale divide ratio equals five-bit code plus two, 2 through 33.
// - writes to slowdown ratio are dropped while slowdown enable is one.
// - recover-on-interrupt set plus interrupt clears slowdown enable in hardware.
// - setting slowdown enable is ignored when the slowdown ratio as it will stand after the write is zero.
// - feedback divisor holds nine writable bits; bits 15-9 read zero.
// - bits 15 to 8 disable pwm generators eight to one when set.
// ------------------------------------------------------------
//
// The plain strobed port and the register offsets were left to the implementer.
module clk_cfg (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // register port
    input  wire logic [3:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    // interrupt request from the core, same clock
    input  wire logic        IRQ,
    // configuration outputs
    output logic      [5:0]  PRESCALE_RATIO,
    output logic      [2:0]  SLOWDOWN_RATIO,
    output logic             SLOWDOWN_ON,
    output logic      [8:0]  FEEDBACK_DIVIDE,
    output logic      [7:0]  PWM_GEN_OFF,
    output logic             SERIAL_PORT3_OFF
);
    clk_cfg_pkg::clock_divisor_t div_r, div_nxt;
    logic [8:0]                  fbd_r;
    clk_cfg_pkg::module_off_t    off_r;
    logic [15:0]                 rd_nxt;
    logic [15:0]                 rdata_r;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire wr_div = WR && (ADDR == clk_cfg_pkg::OFS_CLOCK_DIVISOR);
    wire wr_fbd = WR && (ADDR == clk_cfg_pkg::OFS_PLL_FEEDBACK);
    wire wr_off = WR && (ADDR == clk_cfg_pkg::OFS_MODULE_DISABLE);

    wire [2:0] w_ratio  = WDATA[clk_cfg_pkg::RATIO_LSB +: clk_cfg_pkg::RATIO_W];
    wire       w_en     = WDATA[clk_cfg_pkg::SLOW_EN_BIT];
    // ratio locked while the enable is set; the old enable gates the write
    wire       ratio_ok = !div_r.slowdown_enable;
    wire [2:0] ratio_eff = ratio_ok ? w_ratio : div_r.cpu_slowdown_ratio;
    // enable may only be raised against a nonzero ratio as it will stand
    wire       en_ok    = !w_en || (ratio_eff != 3'h0);
    wire       irq_clr  = IRQ && div_r.recover_on_interrupt;

    always_comb begin
        div_nxt = div_r;
        if (wr_div) begin
            div_nxt.recover_on_interrupt = WDATA[clk_cfg_pkg::RECOVER_BIT];
            div_nxt.pll_input_prescale   = WDATA[clk_cfg_pkg::PRESCALE_LSB +: clk_cfg_pkg::PRESCALE_W];
            div_nxt.cpu_slowdown_ratio   = ratio_eff;
            div_nxt.slowdown_enable      = en_ok ? w_en : div_r.slowdown_enable;
        end
        // hardware clear wins over a software write in the same cycle
        if (irq_clr) begin
            div_nxt.slowdown_enable = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // readback
    // ------------------------------------------------------------
    always_comb begin
        rd_nxt = 16'h0000;
        case (ADDR)
            clk_cfg_pkg::OFS_CLOCK_DIVISOR: begin
                rd_nxt[clk_cfg_pkg::RECOVER_BIT] = div_r.recover_on_interrupt;
                rd_nxt[clk_cfg_pkg::RATIO_LSB +: clk_cfg_pkg::RATIO_W] = div_r.cpu_slowdown_ratio;
                rd_nxt[clk_cfg_pkg::SLOW_EN_BIT] = div_r.slowdown_enable;
                rd_nxt[clk_cfg_pkg::PRESCALE_LSB +: clk_cfg_pkg::PRESCALE_W] = div_r.pll_input_prescale;
            end
            clk_cfg_pkg::OFS_PLL_FEEDBACK: begin
                rd_nxt[clk_cfg_pkg::FEEDBACK_W-1:0] = fbd_r;
            end
            clk_cfg_pkg::OFS_MODULE_DISABLE: begin
                rd_nxt[clk_cfg_pkg::PWM_OFF_LSB +: clk_cfg_pkg::PWM_COUNT] = off_r.pwm_gen_off;
                rd_nxt[clk_cfg_pkg::SPI3_OFF_BIT] = off_r.serial_port3_off;
            end
            default: rd_nxt = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            div_r   <= '{1'b0, clk_cfg_pkg::RATIO_RST, 1'b0, clk_cfg_pkg::PRESCALE_RST};
            fbd_r   <= clk_cfg_pkg::FEEDBACK_RST;
            off_r   <= '0;
            rdata_r <= 16'h0000;
        end else begin
            div_r <= div_nxt;
            if (wr_fbd) begin
                fbd_r <= WDATA[clk_cfg_pkg::FEEDBACK_W-1:0];
            end
            if (wr_off) begin
                off_r.pwm_gen_off      <= WDATA[clk_cfg_pkg::PWM_OFF_LSB +: clk_cfg_pkg::PWM_COUNT];
                off_r.serial_port3_off <= WDATA[clk_cfg_pkg::SPI3_OFF_BIT];
            end
            rdata_r <= RD ? rd_nxt : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign RDATA            = rdata_r;
    assign PRESCALE_RATIO   = {1'b0, div_r.pll_input_prescale} + clk_cfg_pkg::PRESCALE_BIAS;
    assign SLOWDOWN_RATIO   = div_r.cpu_slowdown_ratio;
    assign SLOWDOWN_ON      = div_r.slowdown_enable;
    assign FEEDBACK_DIVIDE  = fbd_r;
    assign PWM_GEN_OFF      = off_r.pwm_gen_off;
    assign SERIAL_PORT3_OFF = off_r.serial_port3_off;
endmodule

// >>> logic/clk_cfg_pkg.sv
// constants and carrier types for the clock configuration block
// assumes a 16-bit register port with one-cycle read latency
package clk_cfg_pkg;
    // ------------------------------------------------------------
    // register offsets (word index on the register port)
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CLOCK_DIVISOR   = 4'h0;
    localparam logic [3:0] OFS_PLL_FEEDBACK    = 4'h1;
    localparam logic [3:0] OFS_MODULE_DISABLE  = 4'h2;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PRESCALE_LSB      = 0;
    localparam int PRESCALE_W        = 5;
    localparam int RATIO_LSB         = 12;
    localparam int RATIO_W           = 3;
    localparam int SLOW_EN_BIT       = 11;
    localparam int RECOVER_BIT       = 15;
    localparam int FEEDBACK_W        = 9;
    localparam int PWM_OFF_LSB       = 8;
    localparam int PWM_COUNT         = 8;
    localparam int SPI3_OFF_BIT      = 0;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [4:0] PRESCALE_RST  = 5'h00;
    localparam logic [2:0] RATIO_RST     = 3'h0;
    localparam logic [8:0] FEEDBACK_RST  = 9'h030;
    localparam logic [5:0] PRESCALE_BIAS = 6'h02;

    typedef struct packed {
        logic       recover_on_interrupt;
        logic [2:0] cpu_slowdown_ratio;
        logic       slowdown_enable;
        logic [4:0] pll_input_prescale;
    } clock_divisor_t;

    typedef struct packed {
        logic [7:0] pwm_gen_off;
        logic       serial_port3_off;
    } module_off_t;
endpackage

// >>> dv/clk_cfg_chk.sv
// assertions on the clock configuration register block
// assumes one clock domain; bound onto clk_cfg at the foot of this file
module clk_cfg_chk (
    input wire logic        CLK, SYS_RST, WR, RD, IRQ, SLOWDOWN_ON, SERIAL_PORT3_OFF,
    input wire logic [3:0]  ADDR,
    input wire logic [15:0] WDATA, RDATA,
    input wire logic [5:0]  PRESCALE_RATIO,
    input wire logic [2:0]  SLOWDOWN_RATIO,
    input wire logic [8:0]  FEEDBACK_DIVIDE,
    input wire logic [7:0]  PWM_GEN_OFF
);
    timeunit 1ns;
    timeprecision 1ps;
    wire  div_wr = WR && ADDR == 4'h0;
    logic rec_r;
    // the recover bit is internal, so it is mirrored from writes
    always_ff @(posedge CLK or posedge SYS_RST)
        if (SYS_RST) rec_r <= 1'b0;
        else if (div_wr) rec_r <= WDATA[15];
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    sequence s_irq_hit; IRQ && rec_r; endsequence
    a_prescale_sum: assert property (div_wr |=> PRESCALE_RATIO == $past(WDATA[4:0]) + 6'h02)
        else $error("prescale ratio wrong");
    a_ratio_lock: assert property (div_wr && SLOWDOWN_ON |=> $stable(SLOWDOWN_RATIO))
        else $error("ratio changed while locked");
    a_irq_clear: assert property (s_irq_hit |=> !SLOWDOWN_ON) else $error("slowdown kept");
    a_enable_guard: assert property ($rose(SLOWDOWN_ON) |-> SLOWDOWN_RATIO != 3'h0)
        else $error("enable set with zero ratio");
    a_fb_read: assert property (RD && ADDR == 4'h1 |=> RDATA == {7'h00, FEEDBACK_DIVIDE})
        else $error("feedback read wrong");
    a_pwm_write: assert property (WR && ADDR == 4'h2 |=> PWM_GEN_OFF == $past(WDATA[15:8]))
        else $error("pwm gating wrong");
    a_mod_read: assert property (RD && ADDR == 4'h2 |=> RDATA == {PWM_GEN_OFF, 7'h00, SERIAL_PORT3_OFF})
        else $error("module read wrong");
    a_read_idle: assert property (!RD |=> RDATA == 16'h0000) else $error("read data not idle");
endmodule
bind clk_cfg clk_cfg_chk chk_u (.CLK, .SYS_RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ, .PRESCALE_RATIO,
    .SLOWDOWN_RATIO, .SLOWDOWN_ON, .FEEDBACK_DIVIDE, .PWM_GEN_OFF, .SERIAL_PORT3_OFF);

// >>> dv/test_clk_cfg.sv
// self-checking bench for the clock configuration registers
// drives the register port and interrupt level directly
module test_clk_cfg;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CLK = 1'b0, SYS_RST = 1'b1, WR = 1'b0, RD = 1'b0, IRQ = 1'b0, SLOWDOWN_ON, SERIAL_PORT3_OFF;
    logic [3:0]  ADDR = 4'h0;
    logic [15:0] WDATA = 16'h0000, RDATA;
    logic [5:0]  PRESCALE_RATIO;
    logic [2:0]  SLOWDOWN_RATIO;
    logic [8:0]  FEEDBACK_DIVIDE;
    logic [7:0]  PWM_GEN_OFF;
    int          miscompares = 0, num_checks = 0, cycles = 0;
    clk_cfg dut_u (.CLK, .SYS_RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ, .PRESCALE_RATIO,
        .SLOWDOWN_RATIO, .SLOWDOWN_ON, .FEEDBACK_DIVIDE, .PWM_GEN_OFF, .SERIAL_PORT3_OFF);
    always #2.5 CLK = ~CLK;
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge CLK) {WR, ADDR, WDATA} <= {1'b1, a, d};
        @(posedge CLK) WR <= 1'b0;
        @(negedge CLK);
    endtask
    task automatic rd(logic [3:0] a, logic [15:0] e);
        @(posedge CLK) {RD, ADDR} <= {1'b1, a};
        @(posedge CLK) RD <= 1'b0;
        @(negedge CLK) chk("read data", e, RDATA);
    endtask
    task automatic t_prescale();
        for (int c = 0; c < 32; c += 31) begin
            wr(4'h0, 16'h07E0 | 16'(c));
            chk("prescale", 16'(c + 2), {10'h000, PRESCALE_RATIO});
            rd(4'h0, 16'(c));
        end
    endtask
    task automatic t_slowdown();
        wr(4'h0, 16'h8800);
        chk("enable", 16'h0000, {15'h0000, SLOWDOWN_ON});
        wr(4'h0, 16'hB800);
        wr(4'h0, 16'hD800);
        chk("slowdown", 16'h000B, {12'h000, SLOWDOWN_ON, SLOWDOWN_RATIO});
        @(posedge CLK) IRQ <= 1'b1;
        @(posedge CLK) IRQ <= 1'b0;
        @(negedge CLK) chk("enable", 16'h0000, {15'h0000, SLOWDOWN_ON});
        // with recover clear an interrupt must leave the enable alone
        wr(4'h0, 16'h3800);
        @(posedge CLK) IRQ <= 1'b1;
        @(posedge CLK) IRQ <= 1'b0;
        @(negedge CLK) chk("enable kept", 16'h0001, {15'h0000, SLOWDOWN_ON});
    endtask
    task automatic t_regs();
        rd(4'h1, {7'h00, clk_cfg_pkg::FEEDBACK_RST});
        wr(4'h1, 16'hFFFF);
        rd(4'h1, 16'h01FF);
        wr(4'h2, 16'hFFFF);
        rd(4'h2, 16'hFF01);
        wr(4'h2, 16'h8000);
        chk("module off", 16'h0100, {7'h00, PWM_GEN_OFF, SERIAL_PORT3_OFF});
        wr(4'hF, 16'hFFFF);
        rd(4'hF, 16'h0000);
        rd(4'h2, 16'h8000);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge CLK);
        SYS_RST <= 1'b0;
        rd(4'h0, 16'h0000);
        t_regs();
        t_prescale();
        t_slowdown();
        complete_run();
    end
    // a hang is cut short well beyond the sixty or so cycles the run needs
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            complete_run();
        end
    end
endmodule
